// ### logic/tecd_pkg.sv
/*
 * tecd_pkg: register offsets, field positions, reset values and mode codes
 * for one event counter / frequency divider timer channel.
 * assumes: a plain address/strobe register port, 16-bit data.
 */
package tecd_pkg;
    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [3:0] OFS_MODE     = 4'h0;
    localparam logic [3:0] OFS_RELOAD   = 4'h1;
    localparam logic [3:0] OFS_COUNTER  = 4'h2;
    localparam logic [3:0] OFS_TRIGGER  = 4'h3;
    localparam logic [3:0] OFS_STATUS   = 4'h4;
    localparam logic [3:0] OFS_OUT_LVL  = 4'h5;
    localparam logic [3:0] OFS_OUT_EN   = 4'h6;
    localparam logic [3:0] OFS_OUT_POL  = 4'h7;
    localparam logic [3:0] OFS_OUT_STY  = 4'h8;
    localparam logic [3:0] OFS_UNIT_EN  = 4'h9;
    localparam logic [3:0] OFS_PRESCALE = 4'ha;

    // ------------------------------------------------------------------
    // mode and trigger register fields
    // ------------------------------------------------------------------
    localparam int MODE_OP_CLK_POS    = 15;
    localparam int MODE_CNT_CLK_POS   = 12;
    localparam int MODE_MASTER_POS    = 11;
    localparam int MODE_TRIG_LSB      = 8;
    localparam int MODE_EDGE_LSB      = 6;
    localparam int MODE_FIELD_LSB     = 1;
    localparam int MODE_START_BHV_POS = 0;
    localparam int TRIG_START_POS     = 0;
    localparam int TRIG_STOP_POS      = 1;

    // ------------------------------------------------------------------
    // codes and reset values
    // ------------------------------------------------------------------
    localparam logic [2:0]  MODE_INTERVAL  = 3'h0;
    localparam logic [2:0]  MODE_EVENT     = 3'h3;
    localparam logic [2:0]  TRIG_SOFTWARE  = 3'h0;
    localparam logic [1:0]  EDGE_FALL      = 2'h0;
    localparam logic [1:0]  EDGE_RISE      = 2'h1;
    localparam logic [1:0]  EDGE_BOTH      = 2'h2;
    localparam logic [15:0] MODE_RESET     = 16'h0000;
    localparam logic [15:0] RELOAD_RESET   = 16'hffff;
    localparam logic [15:0] COUNTER_RESET  = 16'hffff;
    localparam logic [7:0]  PRESCALE_RESET = 8'h00;
    localparam logic [15:0] COUNT_ZERO     = 16'h0000;

    typedef enum logic [2:0] {
        TECD_IDLE = 3'b001,
        TECD_WAIT = 3'b010,
        TECD_RUN  = 3'b100
    } tecd_state_type;
endpackage

// ### logic/tecd_channel.sv
/*
 * tecd_channel: one timer channel as external event counter or as
 * frequency divider of the timer input pin.
 * assumes: register port synchronous to core_clk_i, input pin asynchronous.
 */
// Operation
// RULE1: mode code 011 makes the counter count down on input edges.
// RULE2: event mode start loads reload value at once, then waits for edges.
// RULE3: each selected valid input edge decrements the counter by one.
// RULE4: at zero the counter reloads and raises the interrupt, repeatedly.
// RULE5: reload register writable while running; takes effect next period.
// RULE6: software keeps output enable cleared in event count mode.
// RULE7: edge field 00 falling, 01 rising, 10 both, 11 prohibited.
// RULE8: trigger select 000 means start only by software trigger.
// RULE9: count clock select one counts valid input edges.
// RULE10: operation clock select picks prescaled clock a or b.
// RULE11: start-behaviour bit one gives interrupt and toggle at first load.
// RULE12: divider uses interval mode code with edge counting.
// RULE13: divider loads reload value at first valid edge after start.
// RULE14: divider decrements per edge; at zero toggles, interrupts, reloads.
// RULE15: output frequency is input over 2(reload+1), both edges over reload+1.
// RULE16: edge sampling adds up to one operation clock of period error.
// RULE17: start and stop trigger bits read back as zero.
// RULE18: start sets enable status; stop clears it, freezes counter and output.
// RULE19: software changes only the reload value while running.
// RULE20: output enable one lets counting toggle the output.
// RULE21: output disabled or stopped shows the direct output level bit.
// RULE22: unit clock gate zero ignores writes and resets the channel.
// RULE23: input pin passes a two-stage synchroniser on the operation clock.
`timescale 1ns/1ps
`default_nettype none
module tecd_channel
    import tecd_pkg::*;
#(
    parameter int DATA_W = 16
) (
    input  wire logic              core_clk_i,
    input  wire logic              rst_i,
    input  wire logic [3:0]        reg_addr_i,
    input  wire logic [DATA_W-1:0] reg_wdata_i,
    input  wire logic              reg_wr_i,
    input  wire logic              reg_rd_i,
    output logic      [DATA_W-1:0] reg_rdata_o,
    input  wire logic              timer_input_pin_i,
    output logic                   timer_output_pin_o,
    output logic                   channel_interrupt_o
);
    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [15:0]       mode_q;
    logic [DATA_W-1:0] reload_q;
    logic [DATA_W-1:0] counter_q;
    logic              enable_q;
    logic              unit_en_q;
    logic [7:0]        prescale_q;
    logic              out_lvl_q;
    logic              out_en_q;
    logic              out_pol_q;
    logic              out_sty_q;
    logic [DATA_W-1:0] rdata_q;
    logic              irq_q;
    logic              tout_q;
    tecd_state_type    state_q;
    tecd_state_type    state_d;
    logic [3:0]        pre_cnt_q;
    logic              sync1_q;
    logic              sync2_q;
    logic              sync3_q;

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    wire       wr_ok      = reg_wr_i && unit_en_q;                 // [RULE22]
    wire       wr_mode    = wr_ok && (reg_addr_i == OFS_MODE);
    wire       wr_reload  = wr_ok && (reg_addr_i == OFS_RELOAD);   // [RULE5] [RULE19]
    wire       wr_trig    = wr_ok && (reg_addr_i == OFS_TRIGGER);
    wire       wr_lvl     = wr_ok && (reg_addr_i == OFS_OUT_LVL);
    wire       wr_en      = wr_ok && (reg_addr_i == OFS_OUT_EN);
    wire       wr_pol     = wr_ok && (reg_addr_i == OFS_OUT_POL);
    wire       wr_sty     = wr_ok && (reg_addr_i == OFS_OUT_STY);
    wire       wr_pre     = wr_ok && (reg_addr_i == OFS_PRESCALE);
    wire       wr_unit    = reg_wr_i && (reg_addr_i == OFS_UNIT_EN);
    wire       start_trig = wr_trig && reg_wdata_i[TRIG_START_POS]; // [RULE17]
    wire       stop_trig  = wr_trig && reg_wdata_i[TRIG_STOP_POS];  // [RULE17]
    wire       unit_rst   = rst_i || (wr_unit && !reg_wdata_i[0]);  // [RULE22]

    wire       op_clk_b   = mode_q[MODE_OP_CLK_POS];
    wire       cnt_edge   = mode_q[MODE_CNT_CLK_POS];
    wire [2:0] trig_sel   = mode_q[MODE_TRIG_LSB +: 3];
    wire [1:0] edge_sel   = mode_q[MODE_EDGE_LSB +: 2];
    wire [2:0] mode_fld   = mode_q[MODE_FIELD_LSB +: 3];
    wire       start_bhv  = mode_q[MODE_START_BHV_POS];
    wire       is_event   = (mode_fld == MODE_EVENT);                // [RULE1]
    wire       is_divider = (mode_fld == MODE_INTERVAL) && cnt_edge; // [RULE12] [RULE9]
    wire       sw_start   = (trig_sel == TRIG_SOFTWARE);             // [RULE8]

    // ------------------------------------------------------------------
    // prescaled operation clock ticks
    // ------------------------------------------------------------------
    wire [3:0] div_a    = prescale_q[3:0];
    wire [3:0] div_b    = prescale_q[7:4];
    wire [3:0] div_sel  = op_clk_b ? div_b : div_a;                  // [RULE10]
    wire       op_tick  = (pre_cnt_q >= div_sel);

    always_ff @(posedge core_clk_i) begin
        if (unit_rst || op_tick) begin
            pre_cnt_q <= 4'h0;
        end else begin
            pre_cnt_q <= pre_cnt_q + 4'h1;
        end
    end

    // ------------------------------------------------------------------
    // input synchroniser and edge detect
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (unit_rst) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
        end else if (op_tick) begin
            sync1_q <= timer_input_pin_i;                           // [RULE23]
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    wire rise  = op_tick && sync2_q && !sync3_q;                     // [RULE16]
    wire fall  = op_tick && !sync2_q && sync3_q;
    wire valid_edge = (edge_sel == EDGE_FALL) ? fall :               // [RULE7]
                      (edge_sel == EDGE_RISE) ? rise :
                      (edge_sel == EDGE_BOTH) ? (rise || fall) : 1'b0;
    wire counting   = sw_start && (is_event || is_divider);

    // ------------------------------------------------------------------
    // channel state machine
    // ------------------------------------------------------------------
    wire at_zero   = (counter_q == COUNT_ZERO[DATA_W-1:0]);
    wire first_ld  = (state_q == TECD_WAIT) && valid_edge;           // [RULE13]
    wire run_edge  = (state_q == TECD_RUN) && valid_edge;            // [RULE3]
    wire wrap      = run_edge && at_zero;                            // [RULE4] [RULE14]
    wire start_evt = start_trig && counting && is_event;             // [RULE2]
    wire start_div = start_trig && counting && is_divider;
    wire init_fire = (first_ld || start_evt) && start_bhv;           // [RULE11]
    wire fire      = (wrap || init_fire) && !stop_trig;
    wire do_toggle = fire && out_en_q;                               // [RULE20] [RULE6]

    always_comb begin
        state_d = state_q;
        case (state_q)
            TECD_IDLE: begin
                if (start_evt) begin
                    state_d = TECD_RUN;
                end else if (start_div) begin
                    state_d = TECD_WAIT;
                end
            end
            TECD_WAIT: begin
                if (stop_trig) begin
                    state_d = TECD_IDLE;
                end else if (first_ld) begin
                    state_d = TECD_RUN;
                end
            end
            TECD_RUN: begin
                if (stop_trig) begin
                    state_d = TECD_IDLE;                             // [RULE18]
                end else if (start_div) begin
                    state_d = TECD_WAIT;
                end
            end
            default: state_d = TECD_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (unit_rst) begin
            state_q  <= TECD_IDLE;
            enable_q <= 1'b0;
        end else begin
            state_q  <= state_d;
            enable_q <= (state_d != TECD_IDLE);                      // [RULE18]
        end
    end

    // ------------------------------------------------------------------
    // counter
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (unit_rst) begin
            counter_q <= COUNTER_RESET[DATA_W-1:0];
        end else if (stop_trig) begin
            counter_q <= counter_q;                                  // [RULE18]
        end else if (start_evt || first_ld || wrap) begin
            counter_q <= reload_q;                                   // [RULE2] [RULE5] [RULE15]
        end else if (run_edge) begin
            counter_q <= counter_q - 1'b1;                           // [RULE1] [RULE3] [RULE14]
        end
    end

    // ------------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (unit_rst) begin
            mode_q     <= MODE_RESET;
            reload_q   <= RELOAD_RESET[DATA_W-1:0];
            prescale_q <= PRESCALE_RESET;
            out_en_q   <= 1'b0;
            out_pol_q  <= 1'b0;
            out_sty_q  <= 1'b0;
        end else begin
            if (wr_mode) begin
                mode_q <= reg_wdata_i[15:0];
            end
            if (wr_reload) begin
                reload_q <= reg_wdata_i;                             // [RULE5]
            end
            if (wr_pre) begin
                prescale_q <= reg_wdata_i[7:0];
            end
            if (wr_en) begin
                out_en_q <= reg_wdata_i[0];
            end
            if (wr_pol) begin
                out_pol_q <= reg_wdata_i[0];
            end
            if (wr_sty) begin
                out_sty_q <= reg_wdata_i[0];
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            unit_en_q <= 1'b0;
        end else if (wr_unit) begin
            unit_en_q <= reg_wdata_i[0];
        end
    end

    // ------------------------------------------------------------------
    // output level and interrupt
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (unit_rst) begin
            out_lvl_q <= 1'b0;                                       // [RULE22]
        end else if (wr_lvl) begin
            out_lvl_q <= reg_wdata_i[0];
        end else if (do_toggle) begin
            out_lvl_q <= !out_lvl_q;                                 // [RULE14]
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (unit_rst) begin
            irq_q  <= 1'b0;
            tout_q <= 1'b0;
        end else begin
            irq_q  <= fire;                                          // [RULE4] [RULE11]
            tout_q <= out_lvl_q;                                     // [RULE21]
        end
    end

    assign timer_output_pin_o  = tout_q;
    assign channel_interrupt_o = irq_q;

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] rd_mux;
    always_comb begin
        rd_mux = '0;
        case (reg_addr_i)
            OFS_MODE:     rd_mux = mode_q;
            OFS_RELOAD:   rd_mux = reload_q;
            OFS_COUNTER:  rd_mux = counter_q;
            OFS_TRIGGER:  rd_mux = '0;                               // [RULE17]
            OFS_STATUS:   rd_mux = {{(DATA_W-1){1'b0}}, enable_q};
            OFS_OUT_LVL:  rd_mux = {{(DATA_W-1){1'b0}}, out_lvl_q};
            OFS_OUT_EN:   rd_mux = {{(DATA_W-1){1'b0}}, out_en_q};
            OFS_OUT_POL:  rd_mux = {{(DATA_W-1){1'b0}}, out_pol_q};
            OFS_OUT_STY:  rd_mux = {{(DATA_W-1){1'b0}}, out_sty_q};
            OFS_UNIT_EN:  rd_mux = {{(DATA_W-1){1'b0}}, unit_en_q};
            OFS_PRESCALE: rd_mux = {{(DATA_W-8){1'b0}}, prescale_q};
            default:      rd_mux = '0;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            rdata_q <= '0;
        end else if (reg_rd_i) begin
            rdata_q <= rd_mux;
        end else begin
            rdata_q <= '0;
        end
    end

    assign reg_rdata_o = rdata_q;
endmodule
`default_nettype wire

// ### test/tecd_properties.sv
/*
 * tecd_properties: port assertions for tecd_channel.
 * assumes: bound to tecd_channel, one clock, synchronous reset.
 */
`timescale 1ns/1ps
`default_nettype none
module tecd_properties
    import tecd_pkg::*;
(
    input wire logic        core_clk_i,
    input wire logic        rst_i,
    input wire logic [3:0]  reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic        timer_input_pin_i,
    input wire logic        timer_output_pin_o,
    input wire logic        channel_interrupt_o
);
    // ----------------------------------------
    // helper state
    // ----------------------------------------
    logic       pin_q, gate_q, oe_q, run_q;
    logic [4:0] pin_age_q, wr_age_q, stop_age_q;
    wire logic  unit_wr = reg_wr_i && reg_addr_i == OFS_UNIT_EN;
    wire logic  wr_ok   = reg_wr_i && (gate_q || unit_wr);
    wire logic  stop_wr = wr_ok && reg_addr_i == OFS_TRIGGER && reg_wdata_i[1];
    always_ff @(posedge core_clk_i) begin
        pin_q <= timer_input_pin_i;
        if (rst_i) begin
            {gate_q, oe_q, run_q} <= 3'h0;
            {pin_age_q, wr_age_q, stop_age_q} <= 15'h7fff;
        end else begin
            pin_age_q <= (timer_input_pin_i != pin_q) ? 5'h00 : pin_age_q + 5'(pin_age_q != 5'h1f);
            wr_age_q <= (reg_wr_i && !stop_wr) ? 5'h00 : wr_age_q + 5'(wr_age_q != 5'h1f);
            stop_age_q <= run_q ? 5'h00 : stop_age_q + 5'(stop_age_q != 5'h1f);
            if (unit_wr) gate_q <= reg_wdata_i[0];
            if (wr_ok && reg_addr_i == OFS_OUT_EN) oe_q <= reg_wdata_i[0];
            if (wr_ok && reg_addr_i == OFS_TRIGGER && reg_wdata_i[0]) run_q <= 1'b1;
            if (stop_wr) run_q <= 1'b0;
            if (unit_wr && !reg_wdata_i[0]) {oe_q, run_q} <= 2'h0;
        end
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    property p_trig_zero;
        reg_rd_i && reg_addr_i == OFS_TRIGGER |=> reg_rdata_o == 16'h0000;
    endproperty
    a_trig_zero: assert property (p_trig_zero)
        else $error("trigger register read not zero");
    property p_irq_single;
        channel_interrupt_o |=> !channel_interrupt_o;
    endproperty
    a_irq_single: assert property (p_irq_single)
        else $error("interrupt longer than one cycle");
    property p_irq_cause;
        channel_interrupt_o |-> pin_age_q <= 5'd20 || wr_age_q <= 5'd3;
    endproperty
    a_irq_cause: assert property (p_irq_cause)
        else $error("interrupt without input edge or start");
    property p_irq_run;
        channel_interrupt_o |-> run_q || stop_age_q <= 5'd3;
    endproperty
    a_irq_run: assert property (p_irq_run)
        else $error("interrupt while stopped");
    property p_unit_off;
        unit_wr && !reg_wdata_i[0] |-> ##2 !timer_output_pin_o && !channel_interrupt_o;
    endproperty
    a_unit_off: assert property (p_unit_off)
        else $error("unit gate off did not clear output");
    property p_lvl_write;
        wr_ok && reg_addr_i == OFS_OUT_LVL |-> ##2 timer_output_pin_o == $past(reg_wdata_i[0], 2);
    endproperty
    a_lvl_write: assert property (p_lvl_write)
        else $error("output pin does not follow level write");
    property p_pin_cause;
        $changed(timer_output_pin_o) |-> wr_age_q <= 5'd3 || (oe_q && pin_age_q <= 5'd20);
    endproperty
    a_pin_cause: assert property (p_pin_cause)
        else $error("output toggled while disabled");
    property p_stop_hold;
        stop_wr |=> ##1 ($stable(timer_output_pin_o) || wr_age_q <= 5'd2) [*8];
    endproperty
    a_stop_hold: assert property (p_stop_hold)
        else $error("output moved after stop");
endmodule
`default_nettype wire

// ### test/tecd_pulse_src.sv
/*
 * tecd_pulse_src: external pulse source on the timer input pin.
 * assumes: pin idles low, timing free of the core clock.
 */
`timescale 1ns/1ps
`default_nettype none
module tecd_pulse_src (
    output var logic pin_o
);
    // ----------------------------------------
    // pulse train, fast or slow
    // ----------------------------------------
    initial pin_o = 1'b0;
    task automatic pulses(input int n, input int half_ns);
        repeat (n) begin
            #(half_ns) pin_o = 1'b1;
            #(half_ns) pin_o = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// ### test/tb_top.sv
/*
 * tb_top: self-checking bench for tecd_channel.
 * assumes: package, pulse source and checker compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top import tecd_pkg::*; ;
    logic        core_clk_i, rst_i, reg_wr_i, reg_rd_i, rd_seen;
    logic [3:0]  reg_addr_i;
    logic [15:0] reg_wdata_i, reg_rdata_o, exp_q[$];
    wire logic   timer_input_pin_i;
    logic        timer_output_pin_o, channel_interrupt_o;
    int          error_cnt, check_count, irq_cnt, cyc, seed, base, r;
    tecd_pulse_src SRC (.pin_o(timer_input_pin_i));
    tecd_channel DUT (.core_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
        .reg_rdata_o, .timer_input_pin_i, .timer_output_pin_o, .channel_interrupt_o);
    initial begin
        core_clk_i = 1'b0;
        forever #50 core_clk_i = ~core_clk_i;
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge core_clk_i) reg_wr_i <= 1'b0;
        @(posedge core_clk_i);
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge core_clk_i) reg_rd_i <= 1'b0;
        @(posedge core_clk_i);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask
    task automatic event_run(input logic [1:0] es, input logic cks, input logic bhv,
                             input int np, input int half);
        int ev;
        ev = np * ((es == EDGE_BOTH) ? 2 : 1);
        wr(OFS_TRIGGER, 16'h0002);
        wr(OFS_OUT_EN, 16'h0000);
        wr(OFS_MODE, {cks, 3'h1, 1'b0, TRIG_SOFTWARE, es, 2'h0, MODE_EVENT, bhv});
        wr(OFS_RELOAD, 16'h0003);
        base = irq_cnt;
        wr(OFS_TRIGGER, 16'h0001);
        rd(OFS_COUNTER, 16'h0003);
        rd(OFS_STATUS, 16'h0001);
        rd(OFS_TRIGGER, 16'h0000);
        SRC.pulses(np, half);
        idle(16);
        rd(OFS_COUNTER, 16'(3 - ev % 4));
        check("irq", 16'(ev / 4 + bhv), 16'(irq_cnt - base));
    endtask
    task automatic div_run(input logic [1:0] es, input logic bhv, input int np);
        int tog;
        tog = (np * ((es == EDGE_BOTH) ? 2 : 1) - 1) / 2 + bhv;
        wr(OFS_UNIT_EN, 16'h0000);
        wr(OFS_UNIT_EN, 16'h0001);
        wr(OFS_PRESCALE, 16'h0021);
        wr(OFS_MODE, {1'b0, 3'h1, 1'b0, TRIG_SOFTWARE, es, 2'h0, MODE_INTERVAL, bhv});
        wr(OFS_RELOAD, 16'h0001);
        wr(OFS_OUT_LVL, 16'h0000);
        wr(OFS_OUT_EN, 16'h0001);
        base = irq_cnt;
        wr(OFS_TRIGGER, 16'h0001);
        rd(OFS_COUNTER, COUNTER_RESET);
        SRC.pulses(np, 730);
        idle(16);
        check("irq", 16'(tog), 16'(irq_cnt - base));
        check("pin", 16'(tog % 2), {15'h0, timer_output_pin_o});
    endtask
    // ----------------------------------------
    // monitor and timeout
    // ----------------------------------------
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (channel_interrupt_o === 1'b1) irq_cnt <= irq_cnt + 1;
        if (rd_seen) check("rdata", exp_q.pop_front(), reg_rdata_o);
        rd_seen <= reg_rd_i && !rst_i;
        if (cyc == 20000) begin
            error_cnt++;
            end_of_test();
        end
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {rst_i, seed, reg_addr_i, reg_wdata_i, reg_wr_i, reg_rd_i, rd_seen} = {1'b1, 32'd49, 23'h0};
        {error_cnt, check_count, irq_cnt, cyc} = 128'h0;
        idle(12);
        rst_i <= 1'b0;
        idle(1);
        wr(OFS_RELOAD, 16'h1234);
        rd(OFS_RELOAD, RELOAD_RESET);
        rd(OFS_MODE, MODE_RESET);
        rd(OFS_COUNTER, COUNTER_RESET);
        rd(OFS_PRESCALE, {8'h00, PRESCALE_RESET});
        rd(4'hf, 16'h0000);
        wr(OFS_UNIT_EN, 16'h0001);
        wr(OFS_PRESCALE, 16'h0021);
        repeat (4) begin
            r = $random(seed);
            wr(OFS_RELOAD, r[15:0]);
            rd(OFS_RELOAD, r[15:0]);
        end
        for (int k = 0; k < 3; k++) event_run(2'(k), k[0], 1'b0, 6, k[0] ? 1930 : 730);
        event_run(EDGE_FALL, 1'b1, 1'b1, 1, 1930);
        base = irq_cnt;
        wr(OFS_RELOAD, 16'h0005);
        SRC.pulses(2, 730);
        idle(16);
        rd(OFS_COUNTER, 16'h0000);
        SRC.pulses(1, 730);
        idle(16);
        rd(OFS_COUNTER, 16'h0005);
        check("irq", 16'h0001, 16'(irq_cnt - base));
        wr(OFS_TRIGGER, 16'h0002);
        rd(OFS_STATUS, 16'h0000);
        SRC.pulses(2, 730);
        idle(16);
        rd(OFS_COUNTER, 16'h0005);
        for (int k = 0; k < 3; k++) div_run(2'(k), k[0], 5);
        wr(OFS_TRIGGER, 16'h0002);
        r = timer_output_pin_o;
        SRC.pulses(1, 730);
        idle(16);
        rd(OFS_COUNTER, 16'h0000);
        check("pin", 16'(r), {15'h0, timer_output_pin_o});
        wr(OFS_TRIGGER, 16'h0001);
        wr(OFS_OUT_EN, 16'h0000);
        r = timer_output_pin_o;
        SRC.pulses(4, 730);
        idle(16);
        check("pin", 16'(r), {15'h0, timer_output_pin_o});
        wr(OFS_OUT_LVL, 16'h0001);
        idle(1);
        check("pin", 16'h0001, {15'h0, timer_output_pin_o});
        wr(OFS_UNIT_EN, 16'h0000);
        idle(1);
        check("pin", 16'h0000, {15'h0, timer_output_pin_o});
        wr(OFS_UNIT_EN, 16'h0001);
        rd(OFS_OUT_LVL, 16'h0000);
        wr(OFS_OUT_POL, 16'h0001);
        wr(OFS_OUT_STY, 16'h0001);
        rd(OFS_OUT_POL, 16'h0001);
        rd(OFS_OUT_STY, 16'h0001);
        wr(OFS_MODE, 16'h1106);
        wr(OFS_TRIGGER, 16'h0001);
        rd(OFS_STATUS, 16'h0000);
        idle(4);
        end_of_test();
    end
endmodule
bind tecd_channel tecd_properties u_props (.core_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .timer_input_pin_i, .timer_output_pin_o,
    .channel_interrupt_o);
`default_nettype wire
